// ===== hw/cgsw_clock_ctrl.v
// Clock divider with stop and wait low-power mode control.
`timescale 1ns/100ps
`include "cgsw_defines.vh"
module cgsw_clock_ctrl (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire        halt_oscillator_instruction,
   input  wire        gate_clock_instruction,
   input  wire        ext_irq,
   input  wire        int_irq,
   input  wire        t1_count_en,
   input  wire        t1_src_tick,
   input  wire        t1_wr_en,
   input  wire [15:0] t1_wr_data,
   output reg         phase_clk_q,
   output reg         phase_en_q,
   output reg         osc_run_q,
   output wire [15:0] t1_count,
   output wire        t1_ovf,
   output reg  [1:0]  mode_q
);
   // ------------------------------------------------------------
   // Mode encodings and sizes.
   // ------------------------------------------------------------
   localparam [1:0] ST_RUN  = `CGSW_ST_RUN;
   localparam [1:0] ST_STOP = `CGSW_ST_STOP;
   localparam [1:0] ST_WAKE = `CGSW_ST_WAKE;
   localparam [1:0] ST_WAIT = `CGSW_ST_WAIT;
   localparam       N_PINS  = 2;

   // ------------------------------------------------------------
   // Internal signals.
   // ------------------------------------------------------------
   wire [N_PINS-1:0]      pin_raw;
   wire [N_PINS-1:0]      pin_sync;
   reg  [`CGSW_DIV_W-1:0] div_q;
   reg  [1:0]             mode_d;
   reg                    t1_tick;
   wire                   ext_w;
   wire                   int_w;
   wire                   div_tick;
   wire                   in_run;
   wire                   in_stop;
   wire                   in_wake;
   wire                   next_run;
   wire                   next_stop;
   wire                   next_hold;
   wire                   next_wait;
   wire                   stop_wake;
   wire                   wait_wake;
   wire                   load_stop;
   wire                   t1_wr_ok;
   genvar                 g;

   // ------------------------------------------------------------
   // Two-stage synchronisers for the interrupt pins.
   // ------------------------------------------------------------
   assign pin_raw = {int_irq, ext_irq};

   generate
      for (g = 0; g < N_PINS; g = g + 1) begin : g_sync
         reg meta_q;
         reg safe_q;
         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_q <= 1'b0;
               safe_q <= 1'b0;
            end else begin
               meta_q <= pin_raw[g];
               safe_q <= meta_q;
            end
         end
         assign pin_sync[g] = safe_q;
      end
   endgenerate

   assign ext_w = pin_sync[0];
   assign int_w = pin_sync[1];

   // ------------------------------------------------------------
   // Divide by four; the counter halts with the oscillator.
   // ------------------------------------------------------------
   // [RULE_01] divide by four
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= {`CGSW_DIV_W{1'b0}};
      end else if (osc_run_q) begin
         div_q <= div_q + {{(`CGSW_DIV_W-1){1'b0}}, 1'b1};
      end
   end

   assign div_tick = osc_run_q && (div_q == `CGSW_DIV_LAST);

   // ------------------------------------------------------------
   // Mode decode.
   // ------------------------------------------------------------
   assign in_run    = (mode_q == ST_RUN);
   assign in_stop   = (mode_q == ST_STOP);
   assign in_wake   = (mode_q == ST_WAKE);
   assign next_run  = (mode_d == ST_RUN);
   assign next_stop = (mode_d == ST_STOP);
   assign next_wait = (mode_d == ST_WAIT);
   assign next_hold = next_stop || (mode_d == ST_WAKE);

   // ------------------------------------------------------------
   // Wake sources.
   // ------------------------------------------------------------
   // [RULE_06] external wake only
   assign stop_wake = ext_w;
   // [RULE_10] any interrupt ends wait
   assign wait_wake = ext_w || int_w;

   // ------------------------------------------------------------
   // Mode state machine.
   // ------------------------------------------------------------
   always @* begin
      mode_d = mode_q;
      case (mode_q)
         ST_RUN: begin
            if (halt_oscillator_instruction) begin
               mode_d = ST_STOP;
            end else if (gate_clock_instruction) begin
               mode_d = ST_WAIT;
            end
         end
         ST_STOP: begin
            if (stop_wake) begin
               mode_d = ST_WAKE;
            end
         end
         // [RULE_07] resume at overflow
         ST_WAKE: begin
            if (t1_ovf) begin
               mode_d = ST_RUN;
            end
         end
         ST_WAIT: begin
            if (wait_wake) begin
               mode_d = ST_RUN;
            end
         end
         default: begin
            mode_d = ST_RUN;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Mode register.
   // ------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= ST_RUN;
      end else begin
         mode_q <= mode_d;
      end
   end

   // ------------------------------------------------------------
   // Oscillator run control.
   // ------------------------------------------------------------
   // [RULE_02] oscillator halts in stop
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_run_q <= 1'b1;
      end else begin
         osc_run_q <= !next_stop;
      end
   end

   // ------------------------------------------------------------
   // Phase clock output.
   // ------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_clk_q <= 1'b1;
      end else if (next_hold) begin
         // [RULE_03] frozen high in stop
         phase_clk_q <= 1'b1;
      end else if (next_wait) begin
         // [RULE_09] wait gates clock only
         phase_clk_q <= 1'b1;
      end else begin
         phase_clk_q <= (div_q < `CGSW_DIV_HALF);
      end
   end

   // ------------------------------------------------------------
   // Phase enable pulse, running mode only.
   // ------------------------------------------------------------
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_en_q <= 1'b0;
      end else begin
         phase_en_q <= div_tick && in_run && next_run;
      end
   end

   // ------------------------------------------------------------
   // Timer 1 preload, write gate and source selection.
   // ------------------------------------------------------------
   // [RULE_04] preload on stop entry
   assign load_stop = in_run && next_stop;
   assign t1_wr_ok  = t1_wr_en && in_run;

   // [RULE_05] forced oscillator/4 source
   always @* begin
      t1_tick = 1'b0;
      if (in_wake) begin
         t1_tick = div_tick;
      end else if (!in_stop) begin
         t1_tick = t1_count_en && t1_src_tick;
      end
   end

   // ------------------------------------------------------------
   // Timer 1.
   // ------------------------------------------------------------
   cgsw_timer1 u_timer1 (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .load_stop (load_stop),
      .wr_en     (t1_wr_ok),
      .wr_data   (t1_wr_data),
      .tick      (t1_tick),
      .count_q   (t1_count),
      .ovf_q     (t1_ovf)
   );

endmodule // cgsw_clock_ctrl

// ===== hw/cgsw_defines.vh
// Constants for the clock generation and stop/wait control block.
// Summary of operation
// [RULE_01] Internal phase clock is the oscillator input divided by four.
// [RULE_02] Stop halts the oscillator; registers keep contents except timer 1.
// [RULE_03] In stop mode the phase clock is frozen high.
// [RULE_04] Entering stop loads timer 1 low byte FF and high byte 03.
// [RULE_05] In stop, timer 1 counts oscillator/4; own source returns after.
// [RULE_06] Halted oscillator restarts only on reset or external interrupt.
// [RULE_07] External wake starts timer 1; phase clock returns at its overflow.
// [RULE_08] Software masks timer 1 interrupt, enables counting and a wake.
// [RULE_09] Wait gates the phase clock only; it resumes at once on exit.
// [RULE_10] Wait ends on reset or any interrupt, internal ones included.
`ifndef CGSW_DEFINES_VH
`define CGSW_DEFINES_VH
`define CGSW_DIV_RATIO    4
`define CGSW_DIV_W        2
`define CGSW_DIV_LAST     2'h3
`define CGSW_DIV_HALF     2'h2
`define CGSW_T1_RST_LO    8'hFF
`define CGSW_T1_RST_HI    8'h03
`define CGSW_T1_MAX       16'hFFFF
`define CGSW_ST_RUN       2'h0
`define CGSW_ST_STOP      2'h1
`define CGSW_ST_WAKE      2'h2
`define CGSW_ST_WAIT      2'h3
`endif

// ===== hw/cgsw_timer1.v
// Sixteen-bit down counter used as timer 1 with stop-mode preload.
`timescale 1ns/100ps
`include "cgsw_defines.vh"
module cgsw_timer1 (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire        load_stop,
   input  wire        wr_en,
   input  wire [15:0] wr_data,
   input  wire        tick,
   output reg  [15:0] count_q,
   output reg         ovf_q
);
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= {`CGSW_T1_RST_HI, `CGSW_T1_RST_LO};
         ovf_q   <= 1'b0;
      end else begin
         ovf_q <= 1'b0;
         // [RULE_04] stop preload value
         if (load_stop) begin
            count_q <= {`CGSW_T1_RST_HI, `CGSW_T1_RST_LO};
         end else if (wr_en) begin
            count_q <= wr_data;
         end else if (tick) begin
            if (count_q == 16'h0000) begin
               count_q <= `CGSW_T1_MAX;
               ovf_q   <= 1'b1;
            end else begin
               count_q <= count_q - 16'h0001;
            end
         end
      end
   end
endmodule // cgsw_timer1

// ===== tb/cgsw_chk_sva.sv
// Assertions for the clock and low-power control block.
`timescale 1ns/100ps
module cgsw_chk (
   input wire        ref_clk,
   input wire        rst_n,
   input wire        halt_oscillator_instruction,
   input wire        gate_clock_instruction,
   input wire        int_irq,
   input wire        phase_clk_q,
   input wire        phase_en_q,
   input wire        osc_run_q,
   input wire [15:0] t1_count,
   input wire        t1_ovf,
   input wire [1:0]  mode_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence wait_irq;
      (int_irq && mode_q == 2'h3) [*3];
   endsequence
   div_four_a: assert property (phase_en_q |=> !phase_en_q [*3])
      else $error("phase enable spacing wrong");
   stop_entry_a: assert property (
      halt_oscillator_instruction && mode_q == 2'h0 |=>
      mode_q == 2'h1 && !osc_run_q && t1_count == 16'h03FF)
      else $error("stop entry wrong");
   frozen_high_a: assert property (mode_q == 2'h1 |-> phase_clk_q)
      else $error("phase clock not high in stop");
   osc_restart_a: assert property ($rose(osc_run_q) |-> mode_q == 2'h2)
      else $error("oscillator restart without wake");
   wake_count_a: assert property (mode_q == 2'h2 |-> ##[0:4]
      ($changed(t1_count) || mode_q != 2'h2))
      else $error("timer idle while stabilising");
   wake_end_a: assert property (
      t1_ovf && mode_q == 2'h2 |=> mode_q == 2'h0 && !phase_en_q)
      else $error("clock not restored at overflow");
   wait_entry_a: assert property (
      gate_clock_instruction && !halt_oscillator_instruction &&
      mode_q == 2'h0 |=> mode_q == 2'h3 && osc_run_q)
      else $error("wait entry wrong");
   wait_exit_a: assert property (wait_irq |=> mode_q == 2'h0)
      else $error("wait not left on interrupt");
   resume_now_a: assert property (
      mode_q == 2'h0 && $past(mode_q) == 2'h3 |-> ##[0:4] phase_en_q)
      else $error("clock slow to resume");
endmodule // cgsw_chk
bind cgsw_clock_ctrl cgsw_chk cgsw_chk_inst (.*);

// ===== tb/cgsw_wake_src.sv
// Interrupt source and timer enable model at the far side.
`timescale 1ns/100ps
module cgsw_wake_src (
   input  wire       ref_clk,
   input  wire [1:0] req,
   output reg        ext_irq = 1'b0,
   output reg        int_irq = 1'b0,
   output reg        t1_count_en = 1'b1
);
   always @(negedge ref_clk) begin
      {int_irq, ext_irq} <= req;
   end
endmodule // cgsw_wake_src

// ===== tb/testbench.sv
// Self-checking bench for the clock and low-power control block.
`timescale 1ns/100ps
module testbench;
   reg ref_clk = 1'b0, rst_n = 1'b0, hlt = 1'b0, gat = 1'b0;
   reg tick = 1'b0, wen = 1'b0;
   reg [15:0] wdat = 16'h0000;
   reg [1:0] req = 2'h0;
   reg [5:0] rows [0:3];
   wire ext, intr, cen, pclk, pen, orun, ovf;
   wire [15:0] t1c;
   wire [1:0] mode;
   integer num_errors = 0, n_compared = 0, i, k;
   always #25 ref_clk = ~ref_clk;
   cgsw_wake_src cgsw_wake_src_inst (.ref_clk(ref_clk), .req(req),
      .ext_irq(ext), .int_irq(intr), .t1_count_en(cen));
   cgsw_clock_ctrl cgsw_clock_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .halt_oscillator_instruction(hlt), .gate_clock_instruction(gat),
      .ext_irq(ext), .int_irq(intr), .t1_count_en(cen),
      .t1_src_tick(tick), .t1_wr_en(wen), .t1_wr_data(wdat),
      .phase_clk_q(pclk), .phase_en_q(pen), .osc_run_q(orun),
      .t1_count(t1c), .t1_ovf(ovf), .mode_q(mode));
   task check(input [15:0] s, input [15:0] e, input [39:0] nm);
      begin
         n_compared = n_compared + 1;
         if (s !== e) begin
            num_errors = num_errors + 1;
            $display("Error %s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("errors %0d compared %0d", num_errors, n_compared);
         if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   task wait_run;
      begin
         k = 0;
         while (mode !== 2'h0 && k < 6000) begin
            @(negedge ref_clk);
            k = k + 1;
         end
         if (k == 6000) begin
            num_errors = num_errors + 1;
            print_verdict;
         end
      end
   endtask
   initial begin
      rows[0] = 6'h25; rows[1] = 6'h1B; rows[2] = 6'h17; rows[3] = 6'h35;
      repeat (5) @(negedge ref_clk);
      rst_n = 1'b1;
      check(t1c, 16'h03FF, "t1rst");
      k = 0;
      repeat (40) begin
         @(negedge ref_clk);
         k = k + pen;
      end
      check(k, 16'h000A, "div");
      wen = 1'b1; wdat = 16'h0005; @(negedge ref_clk); wen = 1'b0;
      repeat (2) begin
         tick = 1'b1; @(negedge ref_clk); tick = 1'b0; @(negedge ref_clk);
      end
      check(t1c, 16'h0003, "tsrc");
      wen = 1'b1;
      wdat = 16'h0000;
      @(negedge ref_clk);
      wen = 1'b0;
      tick = 1'b1;
      @(negedge ref_clk);
      tick = 1'b0;
      check(ovf, 1'b1, "ovf");
      check(t1c, 16'hFFFF, "trld");
      @(negedge ref_clk);
      check(ovf, 1'b0, "ovfcl");
      $display("reset and divider tests done");
      for (i = 0; i < 4; i = i + 1) begin
         {hlt, gat} = rows[i][5:4]; @(negedge ref_clk); {hlt, gat} = 2'h0;
         @(negedge ref_clk);
         check(mode, rows[i][1:0], "mode");
         check(pclk, 1'b1, "pclk");
         check(orun, rows[i][1:0] == 2'h3, "orun");
         if (i == 0) begin
            req = 2'h2; repeat (10) @(negedge ref_clk);
            check(mode, 2'h1, "nowak");
         end
         req = rows[i][3:2]; wait_run; req = 2'h0;
         check(k > 4000, rows[i][1:0] == 2'h1, "delay");
         repeat (4) @(negedge ref_clk);
         $display("row %0d done", i);
      end
      hlt = 1'b1;
      @(negedge ref_clk);
      hlt = 1'b0;
      @(negedge ref_clk);
      check(orun, 1'b0, "rsstp");
      rst_n = 1'b0;
      #1;
      check(orun, 1'b1, "rsosc");
      check(mode, 2'h0, "rsmod");
      check(t1c, 16'h03FF, "rst1");
      check(pclk, 1'b1, "rsclk");
      check(pen, 1'b0, "rspen");
      repeat (5) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      check(mode, 2'h0, "rsrun");
      check(orun, 1'b1, "rsor2");
      $display("mid-run reset test done");
      print_verdict;
   end
endmodule // testbench
